// File: rtl/global_control_status_regs.sv
// Global control and status register pair with the gating that these bits steer.
// Assumes a host port decoder issuing one-cycle read and write strobes with address
// and data; status sources are on the same clock, the run pin is asynchronous.
`timescale 1ns/1ps
`default_nettype none
module global_control_status_regs
   import gcs_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   input wire logic [15:0] reg_addr,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   output logic reg_rvalid,
   input wire logic run_pin,
   input wire logic ram_check_running,
   input wire logic eeprom_program_cycle,
   input wire logic eeprom_boot_loading,
   input wire logic bist_fail,
   input wire logic eeprom_boot_loading_fail,
   output logic ready,
   input wire logic [15:0] rx_word_strobe,
   input wire logic [15:0] rx_channel_enable,
   output logic [15:0] rx_accept,
   input wire logic [7:0] tx_word_busy,
   input wire logic [7:0] tx_loopback,
   output logic [7:0] tx_seq_reset,
   output logic [7:0] tx_out_enable,
   output logic label_bit_reverse,
   output logic loopback_tx_suppress,
   output logic status7_owner_select,
   input wire logic new_for_host,
   input wire logic new_for_last_transmitter,
   output logic rx_status_bit7,
   output logic [8:0] descriptor_length
);
   typedef struct packed {
      logic [7:0] ctrl;
      logic [7:0] status;
      logic [7:0] rdata;
      logic rvalid;
      logic run_s1;
      logic run_s2;
      logic run_s3;
      logic run_level;
      logic ready;
      logic [15:0] rx_accept;
      logic rx_status7;
      logic [8:0] desc_len;
   } regs_type;

   regs_type st_r;
   regs_type st_nxt;

   localparam regs_type REGS_RESET = '{
      ctrl: CTRL_RESET,
      status: STAT_RESET,
      rdata: 8'h00,
      rvalid: 1'b0,
      run_s1: 1'b0,
      run_s2: 1'b0,
      run_s3: 1'b0,
      run_level: 1'b0,
      ready: 1'b0,
      rx_accept: 16'h0000,
      rx_status7: 1'b0,
      desc_len: DESC_LEN_SHORT
   };

   // =====================================================================
   // Next state
   always_comb begin
      st_nxt = st_r;

      // Host writes land only in the implemented control bits.
      if (reg_wr && (reg_addr == CTRL_ADDR)) begin
         st_nxt.ctrl = reg_wdata & CTRL_WRITE_MASK; // see RQ8 see RQ17
      end

      // Reads only sample; nothing is cleared by a read.
      st_nxt.rvalid = reg_rd;
      st_nxt.rdata = 8'h00; // see RQ17
      if (reg_rd) begin
         unique case (reg_addr)
            CTRL_ADDR, CTRL_COPY_ADDR: st_nxt.rdata = st_r.ctrl; // see RQ8
            STAT_ADDR: st_nxt.rdata = st_r.status; // see RQ9
            default: st_nxt.rdata = 8'h00;
         endcase
      end

      // The run level changes only once the second and third stages agree.
      st_nxt.run_s1 = run_pin;
      st_nxt.run_s2 = st_r.run_s1;
      st_nxt.run_s3 = st_r.run_s2;
      if (st_r.run_s2 == st_r.run_s3) begin
         st_nxt.run_level = st_r.run_s3;
      end

      // Ready drops during any of the busy phases; the register port still answers reads.
      st_nxt.ready = !ram_check_running && !eeprom_program_cycle && !eeprom_boot_loading; // see RQ14

      st_nxt.status[7:6] = 2'b00; // see RQ17
      st_nxt.status[STAT_READY_BIT] = st_nxt.ready; // see RQ10
      st_nxt.status[STAT_ACTIVE_BIT] = st_r.run_level && st_nxt.ready && !st_r.status[STAT_SAFE_BIT]; // see RQ11
      // Safe mode is left only by reset, so the failure stays visible.
      st_nxt.status[STAT_SAFE_BIT] = st_r.status[STAT_SAFE_BIT] || bist_fail || eeprom_boot_loading_fail; // see RQ12
      st_nxt.status[STAT_RAM_BIT] = ram_check_running; // see RQ13
      st_nxt.status[STAT_PROG_BIT] = eeprom_program_cycle; // see RQ14
      st_nxt.status[STAT_BOOT_BIT] = eeprom_boot_loading; // see RQ15

      st_nxt.rx_accept = rx_word_strobe & rx_channel_enable
         & {RX_CHANNELS{st_r.ctrl[CTRL_RX_GLOBAL_BIT]}}; // see RQ1 see RQ16

      st_nxt.rx_status7 = st_r.ctrl[CTRL_OWNER_BIT] ? new_for_host : new_for_last_transmitter; // see RQ6

      st_nxt.desc_len = st_r.ctrl[CTRL_LONG_DESC_BIT] ? DESC_LEN_LONG : DESC_LEN_SHORT; // see RQ7
   end

   // =====================================================================
   // State register
   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= REGS_RESET;
      end else begin
         st_r <= st_nxt;
      end
   end

   // =====================================================================
   // Transmitter gates
   genvar gi;
   generate
      for (gi = 0; gi < TX_CHANNELS; gi++) begin : g_tx
         tx_gate_if gif ();
         assign gif.global_en = st_r.ctrl[CTRL_TX_GLOBAL_BIT]; // see RQ2
         assign gif.suppress = st_r.ctrl[CTRL_LOOP_SUPP_BIT]; // see RQ5
         assign gif.loopback = tx_loopback[gi];
         assign gif.word_busy = tx_word_busy[gi];
         assign tx_seq_reset[gi] = gif.seq_reset;
         assign tx_out_enable[gi] = gif.out_enable;
         tx_gate u_gate (
            .clock(clock),
            .resetn(resetn),
            .port(gif.gate)
         );
      end
   endgenerate

   // =====================================================================
   // Outputs
   assign reg_rdata = st_r.rdata;
   assign reg_rvalid = st_r.rvalid;
   assign ready = st_r.ready;
   assign rx_accept = st_r.rx_accept;
   // The label reversal itself lives in each channel's shifter; this bit steers it.
   assign label_bit_reverse = st_r.ctrl[CTRL_LABEL_REV_BIT]; // see RQ4
   assign loopback_tx_suppress = st_r.ctrl[CTRL_LOOP_SUPP_BIT];
   assign status7_owner_select = st_r.ctrl[CTRL_OWNER_BIT];
   assign rx_status_bit7 = st_r.rx_status7;
   assign descriptor_length = st_r.desc_len;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   sequence ctrl_write_s;
      reg_wr && (reg_addr == CTRL_ADDR);
   endsequence

   sequence ctrl_read_s;
      reg_rd && !reg_wr && ((reg_addr == CTRL_ADDR) || (reg_addr == CTRL_COPY_ADDR));
   endsequence

   sequence stat_read_s;
      reg_rd && !reg_wr && (reg_addr == STAT_ADDR);
   endsequence

   rx_global_gate_a: assert property (!st_r.ctrl[CTRL_RX_GLOBAL_BIT] |=> (rx_accept == 16'h0000)) // see RQ1
      else $error("Receive data accepted while global receive disabled.");

   rx_channel_gate_a: assert property (st_r.ctrl[CTRL_RX_GLOBAL_BIT]
      |=> (rx_accept == $past(rx_word_strobe & rx_channel_enable))) // see RQ16
      else $error("Receive acceptance does not follow channel enables.");

   tx_disable_hold_a: assert property ((!st_r.ctrl[CTRL_TX_GLOBAL_BIT] && (tx_word_busy == 8'h00)) [*2]
      |-> (tx_seq_reset == 8'hFF) && (tx_out_enable == 8'h00)) // see RQ2
      else $error("Transmitters not held in reset while globally disabled.");

   label_rev_a: assert property (ctrl_write_s |=> (label_bit_reverse == $past(reg_wdata[CTRL_LABEL_REV_BIT]))) // see RQ4
      else $error("Label reverse output does not follow a control write.");

   owner_mux_a: assert property (st_r.ctrl[CTRL_OWNER_BIT] && new_for_host && $stable(st_r.ctrl)
      |=> rx_status_bit7) // see RQ6
      else $error("Status bit 7 does not follow host-new flag.");

   desc_len_a: assert property (##1 (descriptor_length ==
      ($past(st_r.ctrl[CTRL_LONG_DESC_BIT]) ? DESC_LEN_LONG : DESC_LEN_SHORT))) // see RQ7
      else $error("Descriptor length does not match control bit 0.");

   ctrl_write_a: assert property (ctrl_write_s |=> (st_r.ctrl == ($past(reg_wdata) & CTRL_WRITE_MASK))) // see RQ8
      else $error("Control write not stored.");

   ctrl_read_a: assert property (ctrl_read_s |=> reg_rvalid && (reg_rdata == $past(st_r.ctrl))) // see RQ8
      else $error("Control readback wrong at either offset.");

   stat_read_a: assert property (stat_read_s |=> reg_rvalid && (reg_rdata == $past(st_r.status))
      && $stable(st_r.ctrl)) // see RQ9
      else $error("Status read wrong or had a side effect.");

   ready_mirror_a: assert property (st_r.status[STAT_READY_BIT] == ready) // see RQ10
      else $error("Status ready bit differs from ready pin.");

   active_needs_run_a: assert property (st_r.status[STAT_ACTIVE_BIT] |-> ready && $past(st_r.run_level)) // see RQ11
      else $error("Active shown without run or ready.");

   safe_sticky_a: assert property ((bist_fail || eeprom_boot_loading_fail) |=> st_r.status[STAT_SAFE_BIT] [*3]) // see RQ12
      else $error("Safe mode not entered or not held.");

   ram_busy_a: assert property (ram_check_running |=> st_r.status[STAT_RAM_BIT] && !ready) // see RQ13
      else $error("RAM check not reported.");

   prog_ready_a: assert property (eeprom_program_cycle |=> st_r.status[STAT_PROG_BIT] && !ready) // see RQ14
      else $error("Ready high during EEPROM programming.");

   boot_load_a: assert property (eeprom_boot_loading |=> st_r.status[STAT_BOOT_BIT]) // see RQ15
      else $error("Boot loading not reported.");

   unused_zero_a: assert property ((st_r.ctrl[5:4] == 2'b00) && (st_r.status[7:6] == 2'b00)) // see RQ17
      else $error("Unused register bits not zero.");
endmodule
`default_nettype wire

// File: include/gcs_pkg.sv
// Constants, offsets and reset values for the global control and status register pair.
// Assumes the host port decoder delivers a 16-bit register address and byte data.
// Function
// RQ1 - Global receive enable clear: every receive bus is ignored.
// RQ2 - Global transmit enable clear: no transmit data, sequencers held in reset.
// RQ3 - On transmit disable, the 32-bit word in progress finishes first.
// RQ4 - Label-reverse bit flips label byte order on all channels.
// RQ5 - Suppress bit keeps loopback transmitters off the external output.
// RQ6 - Control bit 1 picks host-new or transmitter-7-new for status bit 7.
// RQ7 - Control bit 0 sets transmitter 0/1 descriptor length 128 or 256.
// RQ8 - Control register read/write at 0x8000, read-only copy at 0x8001.
// RQ9 - Status register at 0x8002 readable any time, no side effects.
// RQ10 - Status bit 5 mirrors the ready pin.
// RQ11 - Status bit 4 high once run is asserted and normal operation.
// RQ12 - Status bit 3 set on self-test or boot load failure.
// RQ13 - Status bit 2 high while RAM check and clear run.
// RQ14 - Status bit 1 high in EEPROM programming; ready low meanwhile.
// RQ15 - Status bit 0 high while loading from the boot EEPROM.
// RQ16 - Receive channel accepts data only with global and channel enable set.
// RQ17 - Unused bits read zero, writes to them ignored, control resets to zero.
package gcs_pkg;
   // =====================================================================
   // Register offsets
   localparam logic [15:0] CTRL_ADDR = 16'h8000;
   localparam logic [15:0] CTRL_COPY_ADDR = 16'h8001;
   localparam logic [15:0] STAT_ADDR = 16'h8002;
   // =====================================================================
   // Control fields
   localparam int unsigned CTRL_RX_GLOBAL_BIT = 7;
   localparam int unsigned CTRL_TX_GLOBAL_BIT = 6;
   localparam int unsigned CTRL_LABEL_REV_BIT = 3;
   localparam int unsigned CTRL_LOOP_SUPP_BIT = 2;
   localparam int unsigned CTRL_OWNER_BIT = 1;
   localparam int unsigned CTRL_LONG_DESC_BIT = 0;
   localparam logic [7:0] CTRL_WRITE_MASK = 8'hCF;
   localparam logic [7:0] CTRL_RESET = 8'h00;
   // =====================================================================
   // Status fields
   localparam int unsigned STAT_READY_BIT = 5;
   localparam int unsigned STAT_ACTIVE_BIT = 4;
   localparam int unsigned STAT_SAFE_BIT = 3;
   localparam int unsigned STAT_RAM_BIT = 2;
   localparam int unsigned STAT_PROG_BIT = 1;
   localparam int unsigned STAT_BOOT_BIT = 0;
   localparam logic [7:0] STAT_RESET = 8'h00;
   // =====================================================================
   // Sizes and derived values
   localparam int unsigned RX_CHANNELS = 16;
   localparam int unsigned TX_CHANNELS = 8;
   localparam logic [8:0] DESC_LEN_SHORT = 9'h080;
   localparam logic [8:0] DESC_LEN_LONG = 9'h100;
endpackage

// File: include/tx_gate_if.sv
// Signals between the register bank and one transmitter gate.
// Assumes one instance per transmit channel.
`timescale 1ns/1ps
`default_nettype none
interface tx_gate_if;
   logic global_en;
   logic suppress;
   logic loopback;
   logic word_busy;
   logic seq_reset;
   logic out_enable;
   modport gate (input global_en, input suppress, input loopback, input word_busy,
                 output seq_reset, output out_enable);
   modport ctrl (output global_en, output suppress, output loopback, output word_busy,
                 input seq_reset, input out_enable);
endinterface
`default_nettype wire

// File: rtl/tx_gate.sv
// Per-transmitter gate: holds the sequencer in reset and masks the output driver.
// Assumes word_busy stays high from the first to the last bit of a 32-bit word.
`timescale 1ns/1ps
`default_nettype none
module tx_gate
   import gcs_pkg::*;
(
   input wire logic clock,
   input wire logic resetn,
   tx_gate_if.gate port
);
   typedef enum {TXG_RESET, TXG_RUN, TXG_DRAIN} tx_gate_state_type;
   typedef struct packed {
      tx_gate_state_type state;
      logic seq_reset;
      logic out_enable;
   } tx_gate_regs_type;

   tx_gate_regs_type st_r;
   tx_gate_regs_type st_nxt;

   // =====================================================================
   // Sequencer control
   always_comb begin
      st_nxt = st_r;
      unique case (st_r.state)
         TXG_RESET: begin
            if (port.global_en) begin
               st_nxt.state = TXG_RUN;
            end
         end
         TXG_RUN: begin
            // A frame in progress is abandoned, but never a word.
            if (!port.global_en) begin
               st_nxt.state = port.word_busy ? TXG_DRAIN : TXG_RESET; // see RQ3
            end
         end
         TXG_DRAIN: begin
            if (!port.word_busy) begin
               st_nxt.state = TXG_RESET; // see RQ2
            end
         end
      endcase
      st_nxt.seq_reset = (st_nxt.state == TXG_RESET); // see RQ2
      st_nxt.out_enable = (st_nxt.state != TXG_RESET) && !(port.suppress && port.loopback); // see RQ5
   end

   always_ff @(posedge clock or negedge resetn) begin
      if (!resetn) begin
         st_r <= '{state: TXG_RESET, seq_reset: 1'b1, out_enable: 1'b0};
      end else begin
         st_r <= st_nxt;
      end
   end

   assign port.seq_reset = st_r.seq_reset;
   assign port.out_enable = st_r.out_enable;

   // =====================================================================
   // Checks
   default clocking cb @(posedge clock); endclocking
   default disable iff (!resetn);

   idle_reset_a: assert property ((!port.global_en && !port.word_busy) |=> port.seq_reset) // see RQ2
      else $error("Sequencer not in reset while transmit disabled and idle.");
   quiet_reset_a: assert property (port.seq_reset |-> !port.out_enable) // see RQ2
      else $error("Transmit output enabled while sequencer in reset.");
   word_finish_a: assert property ((!port.seq_reset && port.word_busy) |=> !port.seq_reset) // see RQ3
      else $error("Sequencer reset in the middle of a word.");
   loop_mask_a: assert property ((port.suppress && port.loopback) |=> !port.out_enable) // see RQ5
      else $error("Loopback data driven while suppressed.");
endmodule
`default_nettype wire

// File: bench/host_model.sv
// Host side of the register port: single-byte writes and reads.
// Assumes the bench calls its tasks from one process only.
`timescale 1ns/1ps
`default_nettype none
module host_model (
   input wire logic clock,
   input wire logic [7:0] reg_rdata,
   input wire logic reg_rvalid,
   output logic [15:0] reg_addr,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_wdata
);
   // ==============================================================
   // Bus cycles
   initial begin
      reg_addr = 16'h0000;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_wdata = 8'h00;
   end
   // Address and data are inverted when idle so that no stale value looks valid.
   task automatic wr(input logic [15:0] a, input logic [7:0] d);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(posedge clock);
      #1;
      reg_wr = 1'b0;
      reg_addr = ~a;
      reg_wdata = ~d;
   endtask
   // Reads may be issued at any time and must leave the registers unchanged.
   task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic v);
      @(posedge clock);
      #1;
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clock);
      #1;
      reg_rd = 1'b0;
      reg_addr = ~a;
      d = reg_rdata;
      v = reg_rvalid;
   endtask
endmodule
`default_nettype wire

// File: bench/tb_global_control_status_regs.sv
// Self-checking bench for the global control and status register pair.
// Assumes host_model drives the register port; the bench drives all other inputs.
`timescale 1ns/1ps
`default_nettype none
module tb_global_control_status_regs;
   import gcs_pkg::*;
   logic clock, resetn, reg_wr, reg_rd, reg_rvalid, run_pin, ready;
   logic ram_check_running, eeprom_program_cycle, eeprom_boot_loading, bist_fail, eeprom_boot_loading_fail;
   logic label_bit_reverse, loopback_tx_suppress, status7_owner_select, rx_status_bit7;
   logic new_for_host, new_for_last_transmitter;
   logic [15:0] reg_addr, rx_word_strobe, rx_channel_enable, rx_accept;
   logic [7:0] reg_wdata, reg_rdata, tx_word_busy, tx_loopback, tx_seq_reset, tx_out_enable;
   logic [8:0] descriptor_length;
   int n_mismatch;
   int n_compared;
   host_model host (.clock(clock), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid), .reg_addr(reg_addr),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata));
   global_control_status_regs DUT (.clock(clock), .resetn(resetn), .reg_addr(reg_addr), .reg_wr(reg_wr),
      .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .reg_rvalid(reg_rvalid),
      .run_pin(run_pin), .ram_check_running(ram_check_running), .eeprom_program_cycle(eeprom_program_cycle),
      .eeprom_boot_loading(eeprom_boot_loading), .bist_fail(bist_fail), .eeprom_boot_loading_fail(eeprom_boot_loading_fail),
      .ready(ready), .rx_word_strobe(rx_word_strobe), .rx_channel_enable(rx_channel_enable),
      .rx_accept(rx_accept), .tx_word_busy(tx_word_busy), .tx_loopback(tx_loopback),
      .tx_seq_reset(tx_seq_reset), .tx_out_enable(tx_out_enable), .label_bit_reverse(label_bit_reverse),
      .loopback_tx_suppress(loopback_tx_suppress), .status7_owner_select(status7_owner_select),
      .new_for_host(new_for_host), .new_for_last_transmitter(new_for_last_transmitter),
      .rx_status_bit7(rx_status_bit7), .descriptor_length(descriptor_length));
   // ==============================================================
   // Helpers
   initial begin
      clock = 1'b0;
      forever #5 clock = ~clock;
   end
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("wrong value %s expected %h seen %h", name, exp, seen);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clock);
      #1;
   endtask
   task automatic rd_chk(input logic [15:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      host.rd(a, d, v);
      check("reg_rvalid", {15'h0000, v}, 16'h0001);
      check("reg_rdata", {8'h00, d}, {8'h00, exp});
   endtask
   task automatic apply_reset;
      resetn = 1'b0;
      cyc(2);
      resetn = 1'b1;
   endtask
   task automatic end_of_test;
      $display("compared %0d mismatched %0d", n_compared, n_mismatch);
      if (n_mismatch == 0 && n_compared > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask
   // ==============================================================
   // Scenarios
   task automatic t_reset;
      check("tx_seq_reset", {8'h00, tx_seq_reset}, 16'h00FF);
      check("descriptor_length", {7'h00, descriptor_length}, 16'h0080);
      rd_chk(CTRL_ADDR, 8'h00);
      rd_chk(CTRL_COPY_ADDR, 8'h00);
      rd_chk(STAT_ADDR, 8'h20);
      rd_chk(16'h8003, 8'h00);
      cyc(1);
      check("reg_rvalid", {15'h0000, reg_rvalid}, 16'h0000);
      check("reg_rdata", {8'h00, reg_rdata}, 16'h0000);
   endtask
   task automatic t_ctrl;
      host.wr(CTRL_ADDR, 8'hFF);
      rd_chk(CTRL_ADDR, 8'hCF);
      rd_chk(CTRL_COPY_ADDR, 8'hCF);
      check("label_bit_reverse", {15'h0000, label_bit_reverse}, 16'h0001);
      check("loopback_tx_suppress", {15'h0000, loopback_tx_suppress}, 16'h0001);
      check("descriptor_length", {7'h00, descriptor_length}, 16'h0100);
      host.wr(CTRL_COPY_ADDR, 8'h00);
      host.wr(STAT_ADDR, 8'h00);
      rd_chk(CTRL_ADDR, 8'hCF);
      host.wr(CTRL_ADDR, 8'h00);
      cyc(2);
      check("label_bit_reverse", {15'h0000, label_bit_reverse}, 16'h0000);
      check("loopback_tx_suppress", {15'h0000, loopback_tx_suppress}, 16'h0000);
      check("descriptor_length", {7'h00, descriptor_length}, 16'h0080);
   endtask
   task automatic rx_pulse(input logic [15:0] s, input logic [15:0] exp);
      cyc(1);
      rx_word_strobe = s;
      cyc(1);
      rx_word_strobe = 16'h0000;
      check("rx_accept", rx_accept, exp);
   endtask
   task automatic t_rx;
      rx_channel_enable = 16'h00FF;
      rx_pulse(16'hFFFF, 16'h0000);
      host.wr(CTRL_ADDR, 8'h80);
      cyc(1);
      rx_pulse(16'hFFFF, 16'h00FF);
      rx_pulse(16'h8001, 16'h0001);
   endtask
   task automatic t_tx;
      host.wr(CTRL_ADDR, 8'h40);
      cyc(2);
      check("tx_seq_reset", {8'h00, tx_seq_reset}, 16'h0000);
      check("tx_out_enable", {8'h00, tx_out_enable}, 16'h00FF);
      tx_loopback = 8'h02;
      host.wr(CTRL_ADDR, 8'h44);
      cyc(2);
      check("tx_out_enable", {8'h00, tx_out_enable}, 16'h00FD);
      tx_word_busy = 8'h01;
      host.wr(CTRL_ADDR, 8'h00);
      cyc(3);
      check("tx_seq_reset", {8'h00, tx_seq_reset}, 16'h00FE);
      tx_word_busy = 8'h00;
      cyc(3);
      check("tx_seq_reset", {8'h00, tx_seq_reset}, 16'h00FF);
      check("tx_out_enable", {8'h00, tx_out_enable}, 16'h0000);
      tx_loopback = 8'h00;
   endtask
   task automatic t_owner;
      new_for_host = 1'b1;
      host.wr(CTRL_ADDR, 8'h02);
      cyc(2);
      check("rx_status_bit7", {15'h0000, rx_status_bit7}, 16'h0001);
      check("status7_owner_select", {15'h0000, status7_owner_select}, 16'h0001);
      host.wr(CTRL_ADDR, 8'h00);
      cyc(2);
      check("rx_status_bit7", {15'h0000, rx_status_bit7}, 16'h0000);
      check("status7_owner_select", {15'h0000, status7_owner_select}, 16'h0000);
      new_for_last_transmitter = 1'b1;
      cyc(2);
      check("rx_status_bit7", {15'h0000, rx_status_bit7}, 16'h0001);
   endtask
   // Each busy source in turn: ram check, programming, boot load.
   task automatic t_status;
      for (int i = 0; i < 3; i++) begin
         {ram_check_running, eeprom_program_cycle, eeprom_boot_loading} = 3'b100 >> i;
         cyc(2);
         check("ready", {15'h0000, ready}, 16'h0000);
         rd_chk(STAT_ADDR, 8'h04 >> i);
      end
      {ram_check_running, eeprom_program_cycle, eeprom_boot_loading} = 3'b000;
      run_pin = 1'b1;
      cyc(10);
      check("ready", {15'h0000, ready}, 16'h0001);
      rd_chk(STAT_ADDR, 8'h30);
      bist_fail = 1'b1;
      cyc(1);
      bist_fail = 1'b0;
      cyc(2);
      rd_chk(STAT_ADDR, 8'h28);
      rd_chk(STAT_ADDR, 8'h28);
      apply_reset();
      cyc(10);
      rd_chk(STAT_ADDR, 8'h30);
      eeprom_boot_loading_fail = 1'b1;
      cyc(1);
      eeprom_boot_loading_fail = 1'b0;
      cyc(2);
      rd_chk(STAT_ADDR, 8'h28);
      run_pin = 1'b0;
   endtask
   // ==============================================================
   // Main sequence and watchdog
   initial begin
      n_mismatch = 0;
      n_compared = 0;
      {run_pin, ram_check_running, eeprom_program_cycle, eeprom_boot_loading} = 4'h0;
      {bist_fail, eeprom_boot_loading_fail, new_for_host, new_for_last_transmitter} = 4'h0;
      {rx_word_strobe, rx_channel_enable} = 32'h0000_0000;
      {tx_word_busy, tx_loopback} = 16'h0000;
      apply_reset();
      t_reset();
      t_ctrl();
      t_rx();
      t_tx();
      t_owner();
      t_status();
      end_of_test();
   end
   // The scenarios need well under 2000 cycles; this leaves ample margin.
   initial begin
      #100000;
      n_mismatch++;
      end_of_test();
   end
endmodule
`default_nettype wire
